// >>> hdl/ncs_unit.v
// Purpose: bank status, checksum seeds, ranges and results for an nvm controller
// Assumes: classic wishbone slave, 100 MHz mclk, memories answer req/ack
// Notes:   macro status levels pass a two-flop synchroniser
// What this block does
// - bit 12 set on uncorrectable bank-0 read
// - bit 11 one for clean read, else zero
// - bank-0 parity lines read at bits 10:5
// - bit 4 high during bank-0 dump read
// - programming busy on bits 14 and 1
// - high-voltage errors on bits 13 and 0
// - margin-good flags on bits 15 and 2
// - bank-0 drop sensor on bit 3
// - eeprom range: end 27:16, start 11:0
// - bank-1 range: end 31:16, start 15:0
// - bank-0 range resets end 4FFF, start 0
// - bank-1 clear loads accumulator from seed
// - bank-0 clear loads accumulator from seed
// - command bit 2 resets eeprom accumulator
// - command bit 1 starts eeprom dump read
`timescale 1ns/1ps
`include "ncs_defines.vh"
module ncs_unit (
    input  wire        mclk,
    input  wire        rst_b,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output reg         irq,
    // flash macro status levels (asynchronous)
    input  wire        bank1_margin_ok,
    input  wire        bank1_prog_busy,
    input  wire        bank1_hv_error,
    input  wire        bank0_margin_ok,
    input  wire        bank0_prog_busy,
    input  wire        bank0_hv_error,
    input  wire        bank0_drop_sensor,
    // bank-0 ecc result, same clock
    input  wire        bank0_read_strobe,
    input  wire        bank0_ecc_bit_error,
    input  wire        bank0_ecc_uncorrectable,
    input  wire [5:0]  bank0_parity_lines,
    // eeprom dump read port
    output wire        ee_rd_req,
    output wire [11:0] ee_rd_addr,
    input  wire [15:0] ee_rd_data,
    input  wire        ee_rd_ack,
    // flash bank 1 dump read port
    output wire        f1_rd_req,
    output wire [15:0] f1_rd_addr,
    input  wire [31:0] f1_rd_data,
    input  wire        f1_rd_ack,
    // flash bank 0 dump read port
    output wire        f0_rd_req,
    output wire [15:0] f0_rd_addr,
    input  wire [31:0] f0_rd_data,
    input  wire        f0_rd_ack
);
    // ==========================================================
    // storage
    reg  [11:0]        eeprom_range_end;      // eeprom end word
    reg  [11:0]        eeprom_range_start;    // eeprom start word
    reg  [15:0]        bank1_range_end;       // bank-1 end access
    reg  [15:0]        bank1_range_start;     // bank-1 start access
    reg  [15:0]        bank0_range_end;       // bank-0 end access
    reg  [15:0]        bank0_range_start;     // bank-0 start access
    reg  [31:0]        bank1_checksum_seed;   // bank-1 seed
    reg  [31:0]        bank0_checksum_seed;   // bank-0 seed
    reg                ecc_invalid;           // last read uncorrectable
    reg                ecc_clean;             // last read had no error
    reg  [5:0]         parity_hold;           // parity of last read
    reg  [`NCS_IRQ_W-1:0] irq_status;         // sticky events
    reg  [`NCS_IRQ_W-1:0] irq_mask;           // event enables
    reg  [`NCS_IRQ_W-1:0] next_irq_status;    // status next value
    reg                hv0_prev;              // edge detect, bank-0 hv
    reg                hv1_prev;              // edge detect, bank-1 hv
    reg  [22:0]        cmd_pulse;             // one-cycle command bits
    reg  [31:0]        next_rdata;            // read mux output
    // ==========================================================
    // wires
    wire [6:0]  st_sync;                      // synchronised levels
    wire        req = wb_cyc_i & wb_stb_i;    // bus request
    wire        wr_go = req & wb_we_i & wb_ack_o;    // write commits
    wire        ee_busy;                      // eeprom dump running
    wire        f1_busy;                      // bank-1 dump running
    wire        f0_busy;                      // bank-0 dump running
    wire        ee_done;                      // eeprom dump finished
    wire        f1_done;                      // bank-1 dump finished
    wire        f0_done;                      // bank-0 dump finished
    wire [15:0] eeprom_checksum_value;        // eeprom accumulator
    wire [15:0] f1_crc;                       // bank-1 accumulator
    wire [15:0] f0_crc;                       // bank-0 accumulator
    wire [31:0] bank_status;                  // assembled status word
    wire [`NCS_IRQ_W-1:0] irq_events;         // raw events this cycle
    // merge write data into a register by byte enables
    function [31:0] merge;
        input [31:0] old;
        input [31:0] d;
        input [3:0]  sel;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (sel[b])
                    merge[b*8 +: 8] = d[b*8 +: 8];
            end
        end
    endfunction
    // true when this write hits the given offset
    function hit;
        input [7:0] off;
        begin
            hit = wr_go && (wb_adr_i[7:2] == off[7:2]);
        end
    endfunction
    // merged write words, cut to each field's width where they are stored
    wire [31:0] ee_range_merged = merge({4'h0, eeprom_range_end, 4'h0, eeprom_range_start},
                                        wb_dat_i, wb_sel_i);
    wire [31:0] mask_merged     = merge({26'h0000000, irq_mask}, wb_dat_i, wb_sel_i);
    wire [31:0] cmd_merged      = merge(32'h00000000, wb_dat_i, wb_sel_i);
    // ==========================================================
    // synchroniser for macro status levels
    ncs_sync2 #(
        .W (7)
    ) u_sync (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .async_in ({bank1_margin_ok, bank1_prog_busy, bank1_hv_error,
                    bank0_margin_ok, bank0_prog_busy, bank0_hv_error,
                    bank0_drop_sensor}),
        .sync_out (st_sync)
    );
    // ==========================================================
    // dump engines, one per memory
    ncs_dump_engine #(
        .AW (12),
        .DW (16)
    ) u_ee (
        .mclk        (mclk),
        .rst_b       (rst_b),
        .clear       (cmd_pulse[`NCS_CMD_EE_CLEAR]),
        .seed        (`NCS_RST_CRC),
        .start       (cmd_pulse[`NCS_CMD_EE_DUMP]),
        .range_start (eeprom_range_start),
        .range_end   (eeprom_range_end),
        .mem_rdata   (ee_rd_data),
        .mem_ack     (ee_rd_ack),
        .mem_req     (ee_rd_req),
        .mem_addr    (ee_rd_addr),
        .busy        (ee_busy),
        .done        (ee_done),
        .crc         (eeprom_checksum_value)
    );
    ncs_dump_engine #(
        .AW (16),
        .DW (32)
    ) u_f1 (
        .mclk        (mclk),
        .rst_b       (rst_b),
        .clear       (cmd_pulse[`NCS_CMD_F1_CLEAR]),
        .seed        (bank1_checksum_seed[15:0]),
        .start       (cmd_pulse[`NCS_CMD_F1_DUMP]),
        .range_start (bank1_range_start),
        .range_end   (bank1_range_end),
        .mem_rdata   (f1_rd_data),
        .mem_ack     (f1_rd_ack),
        .mem_req     (f1_rd_req),
        .mem_addr    (f1_rd_addr),
        .busy        (f1_busy),
        .done        (f1_done),
        .crc         (f1_crc)
    );
    ncs_dump_engine #(
        .AW (16),
        .DW (32)
    ) u_f0 (
        .mclk        (mclk),
        .rst_b       (rst_b),
        .clear       (cmd_pulse[`NCS_CMD_F0_CLEAR]),
        .seed        (bank0_checksum_seed[15:0]),
        .start       (cmd_pulse[`NCS_CMD_F0_DUMP]),
        .range_start (bank0_range_start),
        .range_end   (bank0_range_end),
        .mem_rdata   (f0_rd_data),
        .mem_ack     (f0_rd_ack),
        .mem_req     (f0_rd_req),
        .mem_addr    (f0_rd_addr),
        .busy        (f0_busy),
        .done        (f0_done),
        .crc         (f0_crc)
    );
    // ==========================================================
    // bank status word
    assign bank_status = {16'h0000,
                          st_sync[6],
                          st_sync[5],
                          st_sync[4],
                          ecc_invalid,
                          ecc_clean,
                          parity_hold,
                          f0_busy,
                          st_sync[0],
                          st_sync[3],
                          st_sync[2],
                          st_sync[1]};
    // ==========================================================
    // ecc outcome of the latest bank-0 read
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ecc_invalid <= 1'b0;
            ecc_clean   <= 1'b1;
            parity_hold <= 6'h00;
        end else if (bank0_read_strobe) begin
            ecc_invalid <= bank0_ecc_uncorrectable;
            ecc_clean   <= ~bank0_ecc_bit_error;
            parity_hold <= bank0_parity_lines;
        end
    end
    // ==========================================================
    // wishbone handshake and read data
    always @* begin
        next_rdata = 32'h00000000;
        case (wb_adr_i[7:2])
            `NCS_OFF_BANK_STATUS >> 2: next_rdata = bank_status;
            `NCS_OFF_EE_RESULT >> 2:   next_rdata = {16'h0000, eeprom_checksum_value};
            `NCS_OFF_EE_RANGE >> 2:    next_rdata = {4'h0, eeprom_range_end,
                                                     4'h0, eeprom_range_start};
            `NCS_OFF_F1_SEED >> 2:     next_rdata = bank1_checksum_seed;
            `NCS_OFF_F1_RESULT >> 2:   next_rdata = {16'h0000, f1_crc};
            `NCS_OFF_F1_RANGE >> 2:    next_rdata = {bank1_range_end, bank1_range_start};
            `NCS_OFF_F0_SEED >> 2:     next_rdata = bank0_checksum_seed;
            `NCS_OFF_F0_RESULT >> 2:   next_rdata = {16'h0000, f0_crc};
            `NCS_OFF_F0_RANGE >> 2:    next_rdata = {bank0_range_end, bank0_range_start};
            `NCS_OFF_IRQ_STATUS >> 2:  next_rdata = {26'h0000000, irq_status};
            `NCS_OFF_IRQ_MASK >> 2:    next_rdata = {26'h0000000, irq_mask};
            default:                   next_rdata = 32'h00000000;
        endcase
    end
    // ack one cycle after request, read data captured with it
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
            if (req & ~wb_ack_o & ~wb_we_i)
                wb_dat_o <= next_rdata;
        end
    end
    // ==========================================================
    // writable registers
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            eeprom_range_end    <= `NCS_RST_EE_END;
            eeprom_range_start  <= `NCS_RST_EE_START;
            bank1_range_end     <= `NCS_RST_F_END;
            bank1_range_start   <= `NCS_RST_F_START;
            bank0_range_end     <= `NCS_RST_F_END;
            bank0_range_start   <= `NCS_RST_F_START;
            bank1_checksum_seed <= `NCS_RST_SEED;
            bank0_checksum_seed <= `NCS_RST_SEED;
            irq_mask            <= {`NCS_IRQ_W{1'b0}};
        end else begin
            if (hit(`NCS_OFF_EE_RANGE)) begin
                eeprom_range_end   <= ee_range_merged[27:16];
                eeprom_range_start <= ee_range_merged[11:0];
            end
            if (hit(`NCS_OFF_F1_RANGE)) begin
                {bank1_range_end, bank1_range_start} <=
                    merge({bank1_range_end, bank1_range_start}, wb_dat_i, wb_sel_i);
            end
            if (hit(`NCS_OFF_F0_RANGE)) begin
                {bank0_range_end, bank0_range_start} <=
                    merge({bank0_range_end, bank0_range_start}, wb_dat_i, wb_sel_i);
            end
            if (hit(`NCS_OFF_F1_SEED))
                bank1_checksum_seed <= merge(bank1_checksum_seed, wb_dat_i, wb_sel_i);
            if (hit(`NCS_OFF_F0_SEED))
                bank0_checksum_seed <= merge(bank0_checksum_seed, wb_dat_i, wb_sel_i);
            if (hit(`NCS_OFF_IRQ_MASK))
                irq_mask <= mask_merged[`NCS_IRQ_W-1:0];
        end
    end
    // ==========================================================
    // command bits: one-cycle pulses, never stored
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_pulse <= 23'h000000;
        end else if (hit(`NCS_OFF_COMMAND)) begin
            cmd_pulse <= cmd_merged[22:0];
        end else begin
            cmd_pulse <= 23'h000000;
        end
    end
    // ==========================================================
    // interrupt events, write-one-to-clear, set wins over clear
    assign irq_events = {st_sync[4] & ~hv1_prev,
                         st_sync[1] & ~hv0_prev,
                         bank0_read_strobe & bank0_ecc_uncorrectable,
                         f1_done, f0_done, ee_done};
    always @* begin
        next_irq_status = irq_status;
        if (hit(`NCS_OFF_IRQ_STATUS))
            next_irq_status = irq_status & ~(wb_dat_i[`NCS_IRQ_W-1:0]
                                             & {`NCS_IRQ_W{wb_sel_i[0]}});
        next_irq_status = next_irq_status | irq_events;
    end
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            irq_status <= {`NCS_IRQ_W{1'b0}};
            irq        <= 1'b0;
            hv0_prev   <= 1'b0;
            hv1_prev   <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq        <= |(next_irq_status & irq_mask);
            hv0_prev   <= st_sync[1];
            hv1_prev   <= st_sync[4];
        end
    end
endmodule // ncs_unit

// >>> pkg/ncs_defines.vh
// Purpose: constants for the nvm checksum and status unit
// Assumes: byte addresses on a 32-bit classic wishbone bus
// Notes:   every offset is word aligned
`ifndef NCS_DEFINES_VH
`define NCS_DEFINES_VH
// ==========================================================
// register offsets (byte addresses)
`define NCS_OFF_COMMAND       8'h04
`define NCS_OFF_BANK_STATUS   8'h0C
`define NCS_OFF_EE_RESULT     8'h10
`define NCS_OFF_EE_RANGE      8'h14
`define NCS_OFF_F1_SEED       8'h18
`define NCS_OFF_F1_RESULT     8'h1C
`define NCS_OFF_F1_RANGE      8'h20
`define NCS_OFF_F0_SEED       8'h24
`define NCS_OFF_F0_RESULT     8'h28
`define NCS_OFF_F0_RANGE      8'h2C
`define NCS_OFF_IRQ_STATUS    8'h30
`define NCS_OFF_IRQ_MASK      8'h34
// ==========================================================
// command register bits (write-only)
`define NCS_CMD_EE_DUMP       1
`define NCS_CMD_EE_CLEAR      2
`define NCS_CMD_F0_DUMP       17
`define NCS_CMD_F0_CLEAR      18
`define NCS_CMD_F1_DUMP       21
`define NCS_CMD_F1_CLEAR      22
// ==========================================================
// bank status bit positions
`define NCS_ST_F1_MARGIN      15
`define NCS_ST_F1_PROG        14
`define NCS_ST_F1_HVERR       13
`define NCS_ST_F0_INVALID     12
`define NCS_ST_F0_CLEAN       11
`define NCS_ST_F0_PAR_HI      10
`define NCS_ST_F0_PAR_LO      5
`define NCS_ST_F0_BUSY        4
`define NCS_ST_F0_DROP        3
`define NCS_ST_F0_MARGIN      2
`define NCS_ST_F0_PROG        1
`define NCS_ST_F0_HVERR       0
// ==========================================================
// interrupt status / mask bits
`define NCS_IRQ_EE_DONE       0
`define NCS_IRQ_F0_DONE       1
`define NCS_IRQ_F1_DONE       2
`define NCS_IRQ_F0_INVALID    3
`define NCS_IRQ_F0_HVERR      4
`define NCS_IRQ_F1_HVERR      5
`define NCS_IRQ_W             6
// ==========================================================
// reset values and checksum constants
`define NCS_RST_SEED          32'h0000FFFF
`define NCS_RST_CRC           16'hFFFF
`define NCS_RST_EE_END        12'h7FF
`define NCS_RST_EE_START      12'h000
`define NCS_RST_F_END         16'h4FFF
`define NCS_RST_F_START       16'h0000
`define NCS_CRC_POLY          16'h1021
`endif

// >>> hdl/ncs_sync2.v
// Purpose: two-flop synchroniser for a group of status levels
// Assumes: inputs are slow levels from the memory macros
// Notes:   stage one feeds stage two only
`timescale 1ns/1ps
module ncs_sync2 #(
    parameter W = 1
) (
    input  wire         mclk,
    input  wire         rst_b,
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);
    reg [W-1:0] stage1;    // metastability catcher
    // ==========================================================
    // two flops in a row
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            stage1   <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // ncs_sync2

// >>> hdl/ncs_dump_engine.v
// Purpose: walks an address range, reads words, folds them into a checksum
// Assumes: memory answers a held request with a one-cycle ack
// Notes:   start while busy is ignored; start above end reads nothing
`timescale 1ns/1ps
`include "ncs_defines.vh"
module ncs_dump_engine #(
    parameter AW = 16,
    parameter DW = 32
) (
    input  wire          mclk,
    input  wire          rst_b,
    input  wire          clear,
    input  wire [15:0]   seed,
    input  wire          start,
    input  wire [AW-1:0] range_start,
    input  wire [AW-1:0] range_end,
    input  wire [DW-1:0] mem_rdata,
    input  wire          mem_ack,
    output reg           mem_req,
    output reg  [AW-1:0] mem_addr,
    output reg           busy,
    output reg           done,
    output reg  [15:0]   crc
);
    localparam S_IDLE = 2'b00;    // waiting for start
    localparam S_REQ  = 2'b01;    // request held until ack
    localparam S_GAP  = 2'b10;    // one idle cycle between words
    reg [1:0]  state;             // walker state
    // folds one data word into the checksum, msb first
    function [15:0] fold;
        input [15:0]   c;
        input [DW-1:0] d;
        integer i;
        reg [15:0] r;
        begin
            r = c;
            for (i = DW - 1; i >= 0; i = i - 1) begin
                if (r[15] ^ d[i])
                    r = {r[14:0], 1'b0} ^ `NCS_CRC_POLY;
                else
                    r = {r[14:0], 1'b0};
            end
            fold = r;
        end
    endfunction
    // ==========================================================
    // walker and accumulator
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state    <= S_IDLE;
            mem_req  <= 1'b0;
            mem_addr <= {AW{1'b0}};
            busy     <= 1'b0;
            done     <= 1'b0;
            crc      <= `NCS_RST_CRC;
        end else begin
            done <= 1'b0;
            if (clear) begin
                crc <= seed;
            end
            case (state)
                S_IDLE: begin
                    if (start && range_start <= range_end) begin
                        mem_addr <= range_start;
                        mem_req  <= 1'b1;
                        busy     <= 1'b1;
                        state    <= S_REQ;
                    end else if (start) begin
                        done <= 1'b1;    // empty range
                    end
                end
                S_REQ: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        if (!clear) begin
                            crc <= fold(crc, mem_rdata);
                        end
                        if (mem_addr == range_end) begin
                            busy  <= 1'b0;
                            done  <= 1'b1;
                            state <= S_IDLE;
                        end else begin
                            mem_addr <= mem_addr + {{(AW-1){1'b0}}, 1'b1};
                            state    <= S_GAP;
                        end
                    end
                end
                S_GAP: begin
                    mem_req <= 1'b1;
                    state   <= S_REQ;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule // ncs_dump_engine

// >>> verification/ncs_unit_props.sv
// Purpose: port assertions for ncs_unit
// Assumes: one clock, async low reset
// Notes:   bound into ncs_unit
`timescale 1ns/1ps
module ncs_unit_chk (
    input logic        mclk,
    input logic        rst_b,
    input logic        wb_cyc_i,
    input logic        wb_stb_i,
    input logic        wb_ack_o,
    input logic        ee_rd_req,
    input logic [11:0] ee_rd_addr,
    input logic        ee_rd_ack,
    input logic        f0_rd_req,
    input logic [15:0] f0_rd_addr,
    input logic        f0_rd_ack
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // ==========================================================
    // bus answer and memory read port handshakes
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
    a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ee_req_hold: assert property (ee_rd_req && !ee_rd_ack |=> ee_rd_req && $stable(ee_rd_addr))
        else $error("ee req drop");
    a_ee_req_gap: assert property (ee_rd_ack |=> !ee_rd_req)
        else $error("ee no gap");
    a_ee_addr_step: assert property (ee_rd_ack ##2 ee_rd_req |-> ee_rd_addr == $past(ee_rd_addr, 2) + 12'h001)
        else $error("ee addr step");
    a_f0_req_hold: assert property (f0_rd_req && !f0_rd_ack |=> f0_rd_req && $stable(f0_rd_addr))
        else $error("f0 req drop");
    a_f0_req_gap: assert property (f0_rd_ack |=> !f0_rd_req)
        else $error("f0 no gap");
    a_f0_addr_step: assert property (f0_rd_ack ##2 f0_rd_req |-> f0_rd_addr == $past(f0_rd_addr, 2) + 16'h0001)
        else $error("f0 addr step");
    c_ee_word: cover property (ee_rd_ack);
    c_f0_word: cover property (f0_rd_ack);
    c_bus_access: cover property (wb_cyc_i && wb_ack_o);
endmodule // ncs_unit_chk
bind ncs_unit ncs_unit_chk u_ncs_unit_chk (.*);

// >>> verification/ncs_mem_model.sv
// Purpose: memory array answering dump reads
// Assumes: request held until ack
// Notes:   data is a pattern of the address
`timescale 1ns/1ps
module ncs_mem_model #(parameter AW = 16, parameter DW = 32, parameter LAT = 0) (
    input  wire          mclk,
    input  wire          req,
    input  wire [AW-1:0] addr,
    output reg           ack = 1'b0,
    output reg  [DW-1:0] rdata = '0
);
    int cnt = 0;   // wait cycles spent
    wire [31:0] word = {2{16'hA5C3 ^ 16'(addr)}};   // pattern word
    // ack after LAT waits; idle data toggles
    always @(posedge mclk) begin
        ack <= 1'b0;
        rdata <= ~rdata;
        if (req && !ack && cnt >= LAT) begin
            ack <= 1'b1;
            rdata <= word[DW-1:0];
            cnt <= 0;
        end else if (req && !ack) cnt <= cnt + 1;
    end
endmodule // ncs_mem_model

// >>> verification/tb_ncs_unit.sv
// Purpose: self-checking bench for ncs_unit
// Assumes: memory models answer with pattern data
// Notes:   registers reached over classic wishbone
`timescale 1ns/1ps
module tb_ncs_unit;
    logic mclk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, strb = 0, berr = 0, unc = 0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hF;
    logic [31:0] dat = 32'h0, q;
    logic [5:0] par = 6'h00;
    logic [6:0] lv = 7'h00;   // asynchronous status levels
    wire [31:0] dato, f1d, f0d;
    wire [15:0] eed, f1a, f0a;
    wire [11:0] eea;
    wire ack, irq, eer, eek, f1r, f1k, f0r, f0k;
    int errors = 0, comparisons = 0, cycles = 0;
    always #5 mclk = ~mclk;
    ncs_unit u_ncs_unit (.mclk(mclk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dato),
        .wb_ack_o(ack), .irq(irq), .bank1_margin_ok(lv[6]), .bank1_prog_busy(lv[5]),
        .bank1_hv_error(lv[4]), .bank0_margin_ok(lv[3]), .bank0_prog_busy(lv[2]),
        .bank0_hv_error(lv[1]), .bank0_drop_sensor(lv[0]), .bank0_read_strobe(strb),
        .bank0_ecc_bit_error(berr), .bank0_ecc_uncorrectable(unc), .bank0_parity_lines(par),
        .ee_rd_req(eer), .ee_rd_addr(eea), .ee_rd_data(eed), .ee_rd_ack(eek),
        .f1_rd_req(f1r), .f1_rd_addr(f1a), .f1_rd_data(f1d), .f1_rd_ack(f1k),
        .f0_rd_req(f0r), .f0_rd_addr(f0a), .f0_rd_data(f0d), .f0_rd_ack(f0k));
    ncs_mem_model #(.AW(12), .DW(16)) u_ncs_mem_model_ee (.mclk(mclk), .req(eer),
        .addr(eea), .ack(eek), .rdata(eed));
    ncs_mem_model #(.LAT(3)) u_ncs_mem_model_f0 (.mclk(mclk), .req(f0r), .addr(f0a),
        .ack(f0k), .rdata(f0d));
    ncs_mem_model #(.LAT(1)) u_ncs_mem_model_f1 (.mclk(mclk), .req(f1r), .addr(f1a),
        .ack(f1k), .rdata(f1d));
    task chk(input string n, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    // one classic cycle, held until ack is sampled
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        do begin @(posedge mclk); n++; end while (ack !== 1'b1 && n < 50);
        q = dato;
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge mclk);
        if (n >= 50) errors++;
    endtask
    function logic [15:0] crc(input logic [15:0] c, input logic [31:0] d, input int nb);
        for (int i = nb - 1; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0);
        return c;
    endfunction
    task t_reset;
        logic [31:0] e [10] = '{32'h800, 32'hFFFF, 32'h7FF0000, 32'hFFFF, 32'hFFFF,
            32'h4FFF0000, 32'hFF78, 32'hFFFF, 32'h4FFF0000, 32'h0};
        wb(1'b1, 8'h10, 32'h0);   // read-only result ignores writes
        sel <= 4'h1;
        wb(1'b1, 8'h24, 32'h12345678);   // low byte lane only
        sel <= 4'hF;
        for (int i = 0; i < 10; i++) begin
            wb(1'b0, i == 9 ? 8'hFC : 8'(12 + 4 * i), 32'h0);
            chk("reset", q, e[i]);
        end
    endtask
    task t_status;
        lv <= 7'h3A; strb <= 1'b1; berr <= 1'b1; unc <= 1'b1; par <= 6'h2A;
        @(posedge mclk);
        strb <= 1'b0;
        repeat (4) @(posedge mclk);
        wb(1'b0, 8'h0C, 32'h0);
        chk("status", q, 32'h7545);
        chk("irq off", irq, 32'h0);
        wb(1'b1, 8'h34, 32'h8);
        wb(1'b0, 8'h30, 32'h0);
        chk("events", q, 32'h38);
        chk("irq on", irq, 32'h1);
        wb(1'b1, 8'h30, 32'h38);
        repeat (2) @(posedge mclk);
        chk("irq clr", irq, 32'h0);
        strb <= 1'b1; berr <= 1'b0; unc <= 1'b0; lv <= 7'h45;
        repeat (3) @(posedge mclk);
        strb <= 1'b0;
        wb(1'b0, 8'h0C, 32'h0);
        chk("clean read", q, 32'h8D4A);
    endtask
    // seed, range, clear, dump, poll, compare
    task dump(input logic [7:0] so, ro, rs, input int cb, db, dw,
              input logic [15:0] sd, st, en, input logic [2:0] dn);
        logic [15:0] e;
        int n;
        e = sd;
        n = 0;
        if (so != 8'h00) wb(1'b1, so, {16'h0, sd});
        wb(1'b1, ro, {en, st});
        wb(1'b1, 8'h04, 32'h1 << cb);
        wb(1'b0, rs, 32'h0);
        chk("seed", q, {16'h0, sd});
        wb(1'b1, 8'h04, 32'h1 << db);
        repeat (3) @(posedge mclk);
        wb(1'b0, 8'h0C, 32'h0);
        if (db == 17) chk("busy", q[4], 32'h1);
        do begin wb(1'b0, 8'h30, 32'h0); n++; end while (!(q[2:0] & dn) && n < 60);
        chk("done", q[2:0] & dn, dn);
        wb(1'b0, 8'h0C, 32'h0);
        chk("idle", q[4], 32'h0);
        for (int a = st; a <= en; a++) e = crc(e, {2{16'hA5C3 ^ a[15:0]}}, dw);
        wb(1'b0, rs, 32'h0);
        chk("crc", q, {16'h0, e});
        wb(1'b1, 8'h30, {29'h0, dn});
    endtask
    task report_and_stop;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge mclk) begin
        if (++cycles == 20000) begin
            errors++;
            report_and_stop;
        end
    end
    initial begin
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        t_reset;
        t_status;
        dump(8'h24, 8'h2C, 8'h28, 18, 17, 32, 16'h1234, 16'h3, 16'h5, 3'b010);
        dump(8'h18, 8'h20, 8'h1C, 22, 21, 32, 16'hBEEF, 16'h7, 16'h7, 3'b100);
        dump(8'h00, 8'h14, 8'h10, 2, 1, 16, 16'hFFFF, 16'h0, 16'h2, 3'b001);
        report_and_stop;
    end
endmodule // tb_ncs_unit
